// file: nvram_delay_count.sv
// loadable down counter with a done flag used for the select, strobe, release, precharge and guard intervals
// assumes synchronous reset and one load at a time
`timescale 1ns/1ps
module nvram_delay_count #(
	parameter int W = 8
) (
	input  wire logic         clk_in,
	input  wire logic         srst_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	output logic              done_out
);
	logic [W-1:0] cnt_q;

	// count down to zero after each load
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_q <= '0;
		end else if (load_in) begin
			cnt_q <= value_in;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// done once the count has run out; kept free of load_in, which the
	// caller derives from done_out, so no combinational loop can form
	assign done_out = (cnt_q == '0);
endmodule : nvram_delay_count

// file: nvram_dev_model.sv
// behavioural model of the 32k x 8 memory on the far side of the bus
// assumes host pins settle at clock edges; no clock of its own
`timescale 1ns/1ps
module nvram_dev_model (
	input  wire logic        sel_n_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	input  wire logic [14:0] addr_in,
	input  wire logic [7:0]  host_d_in,
	input  wire logic        host_oe_in,
	input  wire logic        slow_in,
	output logic [7:0]       bus_out
);
	logic [7:0] mem [0:32767];
	logic [7:0] q = 8'h5a;
	logic       drv;
	// drive only in a read, drop at once on select, strobe or drive
	assign drv = !sel_n_in && we_n_in && !oe_n_in;
	// wrong data until the access time has run
	always @(negedge oe_n_in) begin
		q = ~mem[addr_in];
		#(slow_in ? 25 : 4) q = mem[addr_in];
	end
	// store the bus as the strobe rises
	always @(posedge we_n_in) mem[addr_in] = bus_out;
	// released bus shows the inverse, not the last value
	assign bus_out = drv ? q : (host_oe_in ? host_d_in : ~q);
endmodule : nvram_dev_model

// file: nvram_host_ctrl.sv
// host controller driving the select, strobe and output drive pins of the memory
// assumes power_good_in is synchronous and falls early enough for the down guard
`timescale 1ns/1ps
module nvram_host_ctrl (
	input  wire logic                              clk_in,
	input  wire logic                              srst_in,
	input  wire logic                              power_good_in,
	input  wire logic                              req_valid_in,
	input  wire logic                              req_write_in,
	input  wire logic [nvram_timing_pkg::ADDR_W-1:0] req_addr_in,
	input  wire logic [nvram_timing_pkg::DATA_W-1:0] req_wdata_in,
	output logic                                   req_ready_out,
	output logic                                   rsp_valid_out,
	output logic [nvram_timing_pkg::DATA_W-1:0]    rsp_rdata_out,
	output logic                                   select_n_out,
	output logic                                   write_n_out,
	output logic                                   out_drive_n_out,
	output logic [nvram_timing_pkg::ADDR_W-1:0]    addr_out,
	input  wire logic [nvram_timing_pkg::DATA_W-1:0] data_in,
	output logic [nvram_timing_pkg::DATA_W-1:0]    data_out,
	output logic                                   data_oe_out
);
	localparam int CW = nvram_timing_pkg::CNT_W;

	nvram_timing_pkg::ctrl_state_e state_q;
	logic          is_write_q;
	logic          load_d;
	logic [CW-1:0] value_d;
	logic          wait_done;
	logic [CW-1:0] cycle_cnt_q;

	nvram_delay_count #(.W(CW)) u_delay (
		.clk_in   (clk_in),
		.srst_in  (srst_in),
		.load_in  (load_d),
		.value_in (value_d),
		.done_out (wait_done)
	);

	// sizes a timing constant to the counter width, minus the load cycle
	function automatic logic [CW-1:0] cyc(input int n);
		cyc = CW'(n - 1);
	endfunction : cyc

	// pick the interval to load on each state change
	always_comb begin
		load_d  = 1'b0;
		value_d = '0;
		case (state_q)
			nvram_timing_pkg::ST_GUARD: begin
				if (!power_good_in) begin
					load_d  = 1'b1; // restart guard while supply is low
					value_d = cyc(nvram_timing_pkg::POWER_UP_GUARD_CYC);
				end
			end
			nvram_timing_pkg::ST_IDLE: begin
				if (power_good_in && req_valid_in) begin
					load_d  = 1'b1;
					value_d = req_write_in ? cyc(nvram_timing_pkg::SELECT_ACTIVE_CYC -
						nvram_timing_pkg::WRITE_PULSE_CYC) :
						cyc(nvram_timing_pkg::ACCESS_CYC);
				end
			end
			nvram_timing_pkg::ST_SELECT: begin
				if (wait_done && is_write_q) begin
					load_d  = 1'b1;
					value_d = cyc(nvram_timing_pkg::WRITE_PULSE_CYC);
				end
			end
			nvram_timing_pkg::ST_STROBE: begin
				if (wait_done) begin
					load_d  = 1'b1;
					value_d = cyc(nvram_timing_pkg::RELEASE_CYC);
				end
			end
			nvram_timing_pkg::ST_HOLD: begin
				if (wait_done) begin
					load_d  = 1'b1;
					value_d = cyc(nvram_timing_pkg::PRECHARGE_CYC);
				end
			end
			nvram_timing_pkg::ST_OFF: begin
				load_d  = 1'b1; // guard armed until supply returns
				value_d = cyc(nvram_timing_pkg::POWER_UP_GUARD_CYC);
			end
			default: begin
				load_d  = 1'b0;
				value_d = '0;
			end
		endcase
	end

	// cycle sequencer
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= nvram_timing_pkg::ST_OFF; // guard runs after every reset
		end else begin
			case (state_q)
				nvram_timing_pkg::ST_GUARD: begin
					if (power_good_in && wait_done) begin
						state_q <= nvram_timing_pkg::ST_IDLE;
					end
				end
				nvram_timing_pkg::ST_IDLE: begin
					if (!power_good_in) begin
						state_q <= nvram_timing_pkg::ST_OFF; // select already high
					end else if (req_valid_in) begin
						state_q <= nvram_timing_pkg::ST_SELECT;
					end
				end
				nvram_timing_pkg::ST_SELECT: begin
					if (wait_done) begin
						state_q <= is_write_q ? nvram_timing_pkg::ST_STROBE :
							nvram_timing_pkg::ST_HOLD;
					end
				end
				nvram_timing_pkg::ST_STROBE: begin
					if (wait_done) begin
						state_q <= nvram_timing_pkg::ST_HOLD;
					end
				end
				nvram_timing_pkg::ST_HOLD: begin
					if (wait_done) begin
						state_q <= nvram_timing_pkg::ST_PRECH;
					end
				end
				nvram_timing_pkg::ST_PRECH: begin
					if (wait_done && cycle_cnt_q >= CW'(nvram_timing_pkg::CYCLE_CYC)) begin
						state_q <= nvram_timing_pkg::ST_IDLE;
					end
				end
				nvram_timing_pkg::ST_OFF: begin
					if (power_good_in) begin
						state_q <= nvram_timing_pkg::ST_GUARD;
					end
				end
				default: state_q <= nvram_timing_pkg::ST_GUARD;
			endcase
		end
	end

	// cycles since chip select fell, saturating
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cycle_cnt_q <= '0;
		end else if (state_q == nvram_timing_pkg::ST_IDLE) begin
			cycle_cnt_q <= 8'h01;
		end else if (cycle_cnt_q != 8'hff) begin
			cycle_cnt_q <= cycle_cnt_q + 8'h01;
		end
	end

	// capture request
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			is_write_q <= 1'b0;
			addr_out   <= '0;
			data_out   <= '0;
		end else if (state_q == nvram_timing_pkg::ST_IDLE && power_good_in && req_valid_in) begin
			is_write_q <= req_write_in;
			addr_out   <= req_addr_in; // held through the cycle, covers address hold
			data_out   <= req_wdata_in;
		end
	end

	// pin drive: select low for the active part of each cycle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			select_n_out    <= 1'b1;
			write_n_out     <= 1'b1;
			out_drive_n_out <= 1'b1;
			data_oe_out     <= 1'b0;
		end else begin
			case (state_q)
				nvram_timing_pkg::ST_IDLE: begin
					if (power_good_in && req_valid_in) begin
						select_n_out    <= 1'b0;
						out_drive_n_out <= req_write_in; // read drives output enable low
					end
				end
				nvram_timing_pkg::ST_SELECT: begin
					if (wait_done && is_write_q) begin
						write_n_out <= 1'b0;
						data_oe_out <= 1'b1; // memory has released by now
					end else if (wait_done) begin
						select_n_out    <= 1'b1;
						out_drive_n_out <= 1'b1;
					end
				end
				nvram_timing_pkg::ST_STROBE: begin
					if (wait_done) begin
						write_n_out  <= 1'b1;
						select_n_out <= 1'b1;
					end
				end
				nvram_timing_pkg::ST_HOLD: begin
					if (wait_done) begin
						data_oe_out <= 1'b0; // released with margin past redrive
					end
				end
				default: begin
					select_n_out    <= 1'b1;
					write_n_out     <= 1'b1;
					out_drive_n_out <= 1'b1;
				end
			endcase
		end
	end

	// read data capture and request handshake
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= '0;
			req_ready_out <= 1'b0;
		end else begin
			rsp_valid_out <= 1'b0;
			if (state_q == nvram_timing_pkg::ST_SELECT && wait_done && !is_write_q) begin
				rsp_valid_out <= 1'b1;
				rsp_rdata_out <= data_in; // access time elapsed
			end
			req_ready_out <= (state_q == nvram_timing_pkg::ST_PRECH) && wait_done &&
				cycle_cnt_q >= CW'(nvram_timing_pkg::CYCLE_CYC) && power_good_in;
		end
	end
endmodule : nvram_host_ctrl

// file: nvram_host_ctrl_asserts.sv
// checker for the pin timing of the memory host controller
// assumes a bind to nvram_host_ctrl and a 125 MHz clock
`timescale 1ns/1ps
module nvram_host_ctrl_asserts (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic power_good_in,
	input wire logic rsp_valid_out,
	input wire logic select_n_out,
	input wire logic write_n_out,
	input wire logic out_drive_n_out,
	input wire logic data_oe_out
);
	logic [15:0] lo_q, hi_q, gap_q, pg_q;
	// select run lengths, cycles since select fell, good supply run
	always_ff @(posedge clk_in) begin
		lo_q  <= select_n_out ? 16'h0 : lo_q + 16'h1;
		hi_q  <= srst_in ? 16'hff : (select_n_out ? hi_q + 16'h1 : 16'h0);
		gap_q <= srst_in ? 16'hff : ($fell(select_n_out) ? 16'h1 : gap_q + 16'h1);
		pg_q  <= (srst_in || !power_good_in) ? 16'h0 : pg_q + 16'h1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sel_min_a: assert property ($rose(select_n_out) |-> lo_q >= 16'h13)
		else $error("select low too short");
	sel_max_a: assert property (!select_n_out |-> lo_q < 16'h4e2)
		else $error("select low too long");
	prech_min_a: assert property ($fell(select_n_out) |-> hi_q >= 16'hb)
		else $error("precharge too short");
	cycle_min_a: assert property ($fell(select_n_out) |-> gap_q >= 16'h1e)
		else $error("cycle time too short");
	wr_setup_a: assert property ($rose(write_n_out) |-> lo_q >= 16'h13)
		else $error("strobe rose too early");
	wr_pulse_a: assert property ($fell(write_n_out) |-> !write_n_out [*7])
		else $error("strobe pulse too short");
	wr_mode_a: assert property (!write_n_out |-> !select_n_out && out_drive_n_out)
		else $error("strobe outside write");
	rd_mode_a: assert property (!out_drive_n_out |-> !select_n_out && !data_oe_out)
		else $error("output drive outside read");
	pwr_down_a: assert property ($fell(select_n_out) |-> $past(power_good_in))
		else $error("cycle began without power");
	pwr_up_a: assert property ($fell(select_n_out) |-> pg_q >= 16'hb)
		else $error("cycle began inside guard");
	rd_answer_a: assert property ($rose(select_n_out) && !$past(out_drive_n_out)
		|-> rsp_valid_out)
		else $error("read answer missing");
endmodule : nvram_host_ctrl_asserts
bind nvram_host_ctrl nvram_host_ctrl_asserts asserts_u (.clk_in(clk_in), .srst_in(srst_in),
	.power_good_in(power_good_in), .rsp_valid_out(rsp_valid_out),
	.select_n_out(select_n_out), .write_n_out(write_n_out),
	.out_drive_n_out(out_drive_n_out), .data_oe_out(data_oe_out));

// file: nvram_timing_pkg.sv
// constants for the host-side controller of an asynchronous 32k x 8 nonvolatile memory
// assumes a 125 MHz controller clock; all pin timing counted in whole cycles
// Functional notes
// - each cycle holds chip select low between 150 ns and 10000 ns.
// - in a write, chip select is low at least 150 ns before the write strobe rises.
// - the write strobe stays low at least 50 ns.
// - chip select is held high and stable at least 85 ns before supply falls below 2.7 V.
// - no operation starts until 85 ns after supply reaches 2.7 V.
package nvram_timing_pkg;
	localparam int CLK_PERIOD_NS      = 8;
	localparam int ADDR_W             = 15;
	localparam int DATA_W             = 8;
	// printed times in ns
	localparam int CYCLE_TIME_NS      = 235;
	localparam int SELECT_ACTIVE_NS   = 150;
	localparam int SELECT_ACTIVE_MAX_NS = 10000;
	localparam int PRECHARGE_NS       = 85;
	localparam int ACCESS_NS          = 150;
	localparam int OUT_ACCESS_NS      = 25;
	localparam int RELEASE_NS         = 25;
	localparam int WRITE_PULSE_NS     = 50;
	localparam int DATA_SETUP_NS      = 50;
	localparam int ADDR_HOLD_NS       = 15;
	localparam int REDRIVE_NS         = 10;
	localparam int POWER_DOWN_GUARD_NS = 85;
	localparam int POWER_UP_GUARD_NS  = 85;
	// least times round up, longest round down
	localparam int CYCLE_CYC      = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRECHARGE_CYC  = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int OUT_ACCESS_CYC = (OUT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int RELEASE_CYC    = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REDRIVE_CYC    = (REDRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELECT_ACTIVE_CYC = (SELECT_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELECT_MAX_CYC = SELECT_ACTIVE_MAX_NS / CLK_PERIOD_NS;
	localparam int POWER_DOWN_GUARD_CYC = (POWER_DOWN_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POWER_UP_GUARD_CYC = (POWER_UP_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 8;

	typedef enum logic [2:0] {
		ST_GUARD  = 3'b000,
		ST_IDLE   = 3'b001,
		ST_SELECT = 3'b011,
		ST_STROBE = 3'b010,
		ST_HOLD   = 3'b110,
		ST_PRECH  = 3'b111,
		ST_OFF    = 3'b101
	} ctrl_state_e;
endpackage : nvram_timing_pkg

// file: tb_nvram_host_ctrl.sv
// self-checking bench for the memory host controller
// assumes the model and checker files are compiled first
`timescale 1ns/1ps
module tb_nvram_host_ctrl;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        power_good_in = 1'b1;
	logic        req_valid_in = 1'b0;
	logic        req_write_in = 1'b0;
	logic [14:0] req_addr_in = 15'h0;
	logic [7:0]  req_wdata_in = 8'h0;
	logic        slow_q = 1'b0;
	logic        ready, rsp_v, sel_n, we_n, oe_n, hoe;
	logic [7:0]  rdata, hdata, bus;
	logic [14:0] addr;
	logic [14:0] tab_a [3] = '{15'h0, 15'h7fff, 15'h2aaa};
	logic [7:0]  tab_d [3] = '{8'ha5, 8'h3c, 8'hff};
	int          wait_n;
	int          n_fail = 0;
	int          num_checks = 0;
	always #4 clk_in = ~clk_in;
	nvram_host_ctrl dut_u (.clk_in(clk_in), .srst_in(srst_in), .power_good_in(power_good_in),
		.req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
		.req_wdata_in(req_wdata_in), .req_ready_out(ready), .rsp_valid_out(rsp_v),
		.rsp_rdata_out(rdata), .select_n_out(sel_n), .write_n_out(we_n),
		.out_drive_n_out(oe_n), .addr_out(addr), .data_in(bus), .data_out(hdata),
		.data_oe_out(hoe));
	nvram_dev_model mem_u (.sel_n_in(sel_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(addr),
		.host_d_in(hdata), .host_oe_in(hoe), .slow_in(slow_q), .bus_out(bus));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one access: request held until select falls, then timed to the ready pulse
	task automatic do_op(input logic wr, input logic [14:0] a, input logic [7:0] d);
		int          n;
		logic [15:0] exp_lo;
		@(posedge clk_in);
		req_valid_in <= 1'b1;
		req_write_in <= wr;
		req_addr_in  <= a;
		req_wdata_in <= d;
		wait_n = 0;
		while (sel_n !== 1'b0 && wait_n < 200) begin
			@(negedge clk_in);
			wait_n++;
		end
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		n = 1;
		@(negedge clk_in);
		while (sel_n === 1'b0 && n < 2000) begin
			n++;
			@(negedge clk_in);
		end
		// write select spans the least active time, read one beyond the access time
		exp_lo = wr ? 16'(nvram_timing_pkg::SELECT_ACTIVE_CYC) : 16'(nvram_timing_pkg::ACCESS_CYC);
		chk("select low cycles", exp_lo, n[15:0]);
		if (!wr) begin
			chk("read valid", 16'h1, {15'h0, rsp_v});
			chk("read data", {8'h0, d}, {8'h0, rdata});
		end
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(negedge clk_in);
			n++;
		end
		chk("ready pulse", 16'h1, {15'h0, n < 100});
	endtask : do_op
	// reset, then a request held from release is taken only after the power-up guard
	task automatic t_guard;
		int   n;
		logic ok;
		@(posedge clk_in);
		srst_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		srst_in <= 1'b0;
		req_valid_in <= 1'b1;
		req_write_in <= 1'b0;
		@(negedge clk_in);
		chk("idle pins", 16'he, {12'h0, sel_n, we_n, oe_n, hoe});
		n = 1;
		while (sel_n !== 1'b0 && n < 100) begin
			@(negedge clk_in);
			n++;
		end
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		ok = (n > nvram_timing_pkg::POWER_UP_GUARD_CYC) && (n < 100);
		chk("select in guard", 16'h1, {15'h0, ok});
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(negedge clk_in);
			n++;
		end
		chk("ready after guard", 16'h1, {15'h0, n < 100});
		$display("guard test done");
	endtask : t_guard
	// back-to-back writes, then reads with prompt and slow memory
	task automatic t_rw;
		for (int i = 0; i < 3; i++) do_op(1'b1, tab_a[i], tab_d[i]);
		for (int i = 0; i < 3; i++) begin
			slow_q <= i[0];
			do_op(1'b0, tab_a[i], tab_d[i]);
		end
		$display("read write test done");
	endtask : t_rw
	// supply loss blocks a pending request, restore reopens after the guard
	task automatic t_power;
		int n;
		@(posedge clk_in);
		power_good_in <= 1'b0;
		req_valid_in  <= 1'b1;
		req_write_in  <= 1'b0;
		n = 0;
		repeat (20) begin
			@(negedge clk_in);
			n += (sel_n !== 1'b1);
		end
		chk("select without power", 16'h0, n[15:0]);
		@(posedge clk_in);
		power_good_in <= 1'b1;
		do_op(1'b0, tab_a[1], tab_d[1]);
		chk("guard after restore", 16'h1, {15'h0, wait_n >= 10});
		$display("power test done");
	endtask : t_power
	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// watchdog well past the expected run of a few microseconds
	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end
	initial begin
		t_guard();
		t_rw();
		t_power();
		t_guard();
		do_op(1'b0, tab_a[2], tab_d[2]);
		end_of_test();
	end
endmodule : tb_nvram_host_ctrl
